// ===== logic/interlock_regs.svh
// Offsets, field positions, reset values and timing counts of the clutch/brake interlock.
// Assumes a 40 MHz system clock and a byte-addressed 32-bit register port with 8-bit addresses.
`ifndef INTERLOCK_REGS_SVH
`define INTERLOCK_REGS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SPD_W        12
`define FAULT_N      45
`define ADDR_W       8

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL     8'h00
`define OFS_STATUS   8'h04
`define OFS_MASK     8'h08
`define OFS_FAULT    8'h0c
`define OFS_STATE    8'h10

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define CTRL_EN_BIT  0
`define CTRL_RST     1'b0
`define MASK_RST     4'h0
`define EV_CLUTCH    0
`define EV_BRAKE     1
`define EV_OVERLAP   2
`define EV_FAULT     3

// ----------------------------------------------------------------------------
// Ratings in percent and fault code ranges (BCD digits)
// ----------------------------------------------------------------------------
`define PCT_TRIP     120
`define PCT_LIMIT    100
`define PCT_LINE_LOW 85
`define CODE_MAIN    16'h0101
`define CODE_NOW_HI  8'h02
`define CODE_NOW_LO  2
`define CODE_NOW_N   27
`define CODE_TOP_HI  8'h03
`define CODE_TOP_LO  13

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_MHZ      40
`define GAP_NS       1000
`define GAP_CYC      ((`GAP_NS * `CLK_MHZ + 999) / 1000)

`endif

// ===== logic/interlock_pkg.sv
// Types shared by the clutch/brake interlock and its channel limiter.
// Assumes interlock_regs.svh is on the include path.
`include "interlock_regs.svh"

package interlock_pkg;

  // --------------------------------------------------------------------------
  // Channel sequencer, Gray coded along idle-clutch-gap-brake
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_CLUTCH = 2'b01,
    MODE_GAP    = 2'b11,
    MODE_BRAKE  = 2'b10
  } mode_t;

  typedef logic [`SPD_W-1:0] level_t;

  // Discrete permissives from the press
  typedef struct packed {
    logic run;
    logic clutch_contactor;
    logic brake_contactor;
    logic regulator_inhibit;
    logic phase_ok;
  } cond_t;

  // Gate commands toward the driver boards
  typedef struct packed {
    logic clutch_gate;
    logic brake_gate;
    logic freewheel_clutch;
    logic freewheel_brake;
  } gates_t;

  // Whole register state of the interlock
  typedef struct packed {
    mode_t        mode;
    logic [7:0]   gap_cnt;
    logic         to_brake;
    logic         enable;
    logic [3:0]   mask;
    logic [3:0]   status;
    logic [3:0]   prev_ev;
    gates_t       gates;
    level_t       clutch_drive;
    level_t       brake_drive;
    logic         inhibit;
    logic [15:0]  fault_code;
    logic [31:0]  rd_data;
    logic         irq;
  } state_t;

endpackage : interlock_pkg

// ===== logic/current_limit.sv
// Per-channel error path with current limit: drive follows the speed error and
// is cut back as the coil current nears its rating.
// Assumes inputs are registered upstream; purely combinational.
`timescale 1ns/1ps
`include "interlock_regs.svh"

module current_limit
  import interlock_pkg::*;
#(
  parameter int GAIN_SH = 2
) (
  input  wire level_t demand,
  input  wire level_t actual,
  input  wire level_t current,
  input  wire level_t rated,
  output level_t      drive
);

  logic [`SPD_W:0] err;
  logic [`SPD_W:0] room;

  // ----------------------------------------------------------------------------
  // Error and headroom
  // ----------------------------------------------------------------------------
  // Headroom is scaled up so full forcing is kept until close to rating
  always_comb begin
    err   = (demand > actual) ? ({1'b0, demand} - {1'b0, actual}) : '0;
    room  = (rated > current) ? ({1'b0, rated} - {1'b0, current}) : '0;
    // Clamp before the shift so a large rating cannot wrap to a small limit
    if (room > ({1'b0, {`SPD_W{1'b1}}} >> GAIN_SH)) begin
      room = {1'b0, {`SPD_W{1'b1}}};
    end else begin
      room = room << GAIN_SH;
    end
    if (room < err) begin
      drive = room[`SPD_W-1:0] | {`SPD_W{room[`SPD_W]}};
    end else begin
      drive = err[`SPD_W-1:0] | {`SPD_W{err[`SPD_W]}};
    end
  end

endmodule : current_limit

// ===== logic/clutch_brake_interlock.sv
// Clutch/brake gating and interlock with fault priority encoder and register port.
// Assumes all inputs synchronous to clk_sys and one-cycle bus strobes.
// Operation
// - Reference above feedback: clutch on, brake off together; from brake the code turns brake off and gates clutch after the gap.
// - Clutch held until feedback reaches reference, then drive drops to zero at once.
// - Feedback above reference: clutch off first, then brake on.
// - Brake held only until falling feedback equals reference, then off.
// - Never both channels on; inhibit line high on any overlap risk.
// - Inhibit line high blocks further gating of the affected channel.
// - Clutch blocked: no run, contactor open, regulator inhibit, 120% current, low line.
// - Brake blocked: contactor open, 120% current, 85% line voltage, missing phase.
// - Each channel cuts drive back as coil current nears 100% rating.
// - Free-wheel commands come from coil voltage on a separate path.
// - Clutch and brake keep separate error paths and firing controllers.
// - Monitored faults are ranked by fixed priority for the indicator.
// - The stop-main-motor fault reports code 0101.
// - Stop-now faults report codes 0202 through 0228.
// - Stop-on-top faults report codes 0313 through 0329.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "interlock_regs.svh"

module clutch_brake_interlock
  import interlock_pkg::*;
#(
  parameter level_t RATED_CLUTCH = 12'h700,
  parameter level_t RATED_BRAKE  = 12'h700,
  parameter level_t RATED_LINE   = 12'h800,
  parameter logic [7:0] GAP_CYC  = 8'(`GAP_CYC)
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic [`ADDR_W-1:0]   addr,
  input  wire logic [31:0]          wr_data,
  input  wire logic                 wr_en,
  input  wire logic                 rd_en,
  output logic      [31:0]          rd_data,
  input  wire level_t               speed_ref,
  input  wire level_t               speed_fb,
  input  wire level_t               clutch_current,
  input  wire level_t               brake_current,
  input  wire logic signed [`SPD_W-1:0] clutch_coil_volt,
  input  wire logic signed [`SPD_W-1:0] brake_coil_volt,
  input  wire level_t               line_volt,
  input  wire cond_t                cond,
  input  wire logic [`FAULT_N-1:0]  fault_in,
  output gates_t                    gates,
  output level_t                    clutch_drive,
  output level_t                    brake_drive,
  output logic                      inhibit_line,
  output logic      [15:0]          fault_code,
  output logic                      irq
);

  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  // Percentage of a rating, wide intermediate so the product never wraps
  function automatic level_t pct(input level_t rated, input logic [7:0] p);
    logic [`SPD_W+7:0] prod;
    prod = 20'(rated) * 20'(p);
    pct  = level_t'(prod / 20'd100);
  endfunction : pct

  // Two BCD digits of a value below one hundred
  function automatic logic [7:0] bcd2(input logic [6:0] n);
    logic [3:0] tens;
    logic [3:0] ones;
    tens = 4'(n / 7'd10);
    ones = 4'(n % 7'd10);
    bcd2 = {tens, ones};
  endfunction : bcd2

  // Fault index to indicator code; index 0 is the most urgent
  function automatic logic [15:0] code_of(input logic [6:0] idx);
    if (idx == 7'd0) begin
      code_of = `CODE_MAIN;
    end else if (idx <= 7'(`CODE_NOW_N)) begin
      code_of = {`CODE_NOW_HI, bcd2(7'(idx - 7'd1 + 7'(`CODE_NOW_LO)))};
    end else begin
      code_of = {`CODE_TOP_HI,
                 bcd2(7'(idx - 7'(`CODE_NOW_N) - 7'd1 + 7'(`CODE_TOP_LO)))};
    end
  endfunction : code_of

  state_t r_reg;
  state_t r_next;
  level_t clutch_lim;
  level_t brake_lim;

  // ----------------------------------------------------------------------------
  // Separate error paths per channel
  // ----------------------------------------------------------------------------
  // Clutch pushes up toward reference, brake pulls down toward it
  current_limit #(.GAIN_SH(2)) u_clutch_path (
    .demand  (speed_ref),
    .actual  (speed_fb),
    .current (clutch_current),
    .rated   (RATED_CLUTCH),
    .drive   (clutch_lim)
  );

  current_limit #(.GAIN_SH(2)) u_brake_path (
    .demand  (speed_fb),
    .actual  (speed_ref),
    .current (brake_current),
    .rated   (RATED_BRAKE),
    .drive   (brake_lim)
  );

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  logic        want_clutch;
  logic        want_brake;
  logic        line_low;
  logic        clutch_block;
  logic        brake_block;
  logic        overlap;
  logic        fault_any;
  logic [3:0]  ev;
  logic        hit_wr;
  logic        hit_rd;
  logic [15:0] code_sel;

  always_comb begin
    r_next      = r_reg;
    want_clutch = speed_ref > speed_fb;
    want_brake  = speed_fb > speed_ref;
    line_low    = (line_volt <= pct(RATED_LINE, 8'(`PCT_LINE_LOW)));
    hit_wr      = ce & wr_en;
    hit_rd      = ce & rd_en;

    // Permissives for each channel; disable in control also blocks both
    clutch_block = ~cond.run | ~cond.clutch_contactor | cond.regulator_inhibit
                 | (clutch_current >= pct(RATED_CLUTCH, 8'(`PCT_TRIP)))
                 | line_low | ~cond.phase_ok | ~r_reg.enable;
    brake_block  = ~cond.brake_contactor
                 | (brake_current >= pct(RATED_BRAKE, 8'(`PCT_TRIP)))
                 | line_low | ~cond.phase_ok | ~r_reg.enable;

    // Sequencer: the gap state keeps both channels dark between directions
    case (r_reg.mode)
      MODE_IDLE: begin
        if (want_clutch) begin
          r_next.mode = MODE_CLUTCH;
        end else if (want_brake) begin
          r_next.mode = MODE_BRAKE;
        end
      end
      MODE_CLUTCH: begin
        if (!want_clutch) begin
          if (want_brake) begin
            r_next.mode     = MODE_GAP;
            r_next.gap_cnt  = GAP_CYC;
            r_next.to_brake = 1'b1;
          end else begin
            r_next.mode = MODE_IDLE;
          end
        end
      end
      MODE_BRAKE: begin
        if (!want_brake) begin
          if (want_clutch) begin
            r_next.mode     = MODE_GAP;
            r_next.gap_cnt  = GAP_CYC;
            r_next.to_brake = 1'b0;
          end else begin
            r_next.mode = MODE_IDLE;
          end
        end
      end
      MODE_GAP: begin
        if (r_reg.gap_cnt != 8'h00) begin
          r_next.gap_cnt = r_reg.gap_cnt - 8'h01;
        end else if (r_reg.to_brake && want_brake) begin
          r_next.mode = MODE_BRAKE;
        end else if (!r_reg.to_brake && want_clutch) begin
          r_next.mode = MODE_CLUTCH;
        end else begin
          r_next.mode = MODE_IDLE;
        end
      end
      default: begin
        r_next.mode = MODE_IDLE;
      end
    endcase

    // Overlap guard: separation interval or any request for both at once
    overlap = (r_next.mode == MODE_GAP) | (want_clutch & want_brake);

    // Gates only in their own mode and only while unblocked; exclusive by mode
    r_next.gates.clutch_gate = (r_next.mode == MODE_CLUTCH) & ~clutch_block
                             & ~overlap;
    r_next.gates.brake_gate  = (r_next.mode == MODE_BRAKE) & ~brake_block
                             & ~overlap;
    r_next.inhibit = overlap | clutch_block | brake_block;

    // Drive magnitude is zero whenever its gate is off, so it falls at once
    r_next.clutch_drive = r_next.gates.clutch_gate ? clutch_lim : '0;
    r_next.brake_drive  = r_next.gates.brake_gate ? brake_lim : '0;

    // Free-wheel path looks only at coil voltage reversal with its gate off
    r_next.gates.freewheel_clutch = ~r_next.gates.clutch_gate
                                  & clutch_coil_volt[`SPD_W-1];
    r_next.gates.freewheel_brake  = ~r_next.gates.brake_gate
                                  & brake_coil_volt[`SPD_W-1];

    // Fault priority: scan from least urgent so the most urgent wins
    code_sel  = 16'h0000;
    fault_any = |fault_in;
    for (int i = `FAULT_N - 1; i >= 0; i--) begin
      if (fault_in[i]) begin
        code_sel = code_of(7'(i));
      end
    end
    r_next.fault_code = code_sel;

    // Sticky events on rising conditions; a read clears, a new set wins
    ev = '0;
    ev[`EV_CLUTCH]  = clutch_block;
    ev[`EV_BRAKE]   = brake_block;
    ev[`EV_OVERLAP] = overlap;
    ev[`EV_FAULT]   = fault_any;
    r_next.prev_ev  = ev;
    if (hit_rd && addr == `OFS_STATUS) begin
      r_next.status = 4'h0;
    end
    r_next.status = r_next.status | (ev & ~r_reg.prev_ev);

    // Register writes
    if (hit_wr && addr == `OFS_CTRL) begin
      r_next.enable = wr_data[`CTRL_EN_BIT];
    end
    if (hit_wr && addr == `OFS_MASK) begin
      r_next.mask = wr_data[3:0];
    end

    // Read data stand for exactly the cycle after the strobe
    r_next.rd_data = 32'h0000_0000;
    if (hit_rd) begin
      case (addr)
        `OFS_CTRL:   r_next.rd_data = {31'h0, r_reg.enable};
        `OFS_STATUS: r_next.rd_data = {28'h0, r_reg.status};
        `OFS_MASK:   r_next.rd_data = {28'h0, r_reg.mask};
        `OFS_FAULT:  r_next.rd_data = {16'h0, r_reg.fault_code};
        `OFS_STATE:  r_next.rd_data = {24'h0, r_reg.inhibit, r_reg.gates,
                                       r_reg.to_brake, r_reg.mode};
        default:     r_next.rd_data = 32'h0000_0000;
      endcase
    end

    r_next.irq = |(r_next.status & r_next.mask);
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  // Clock enable freezes everything, including the read-data slot
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r_reg        <= '0;
      r_reg.mode   <= MODE_IDLE;
      r_reg.enable <= `CTRL_RST;
      r_reg.mask   <= `MASK_RST;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------------------
  assign rd_data      = r_reg.rd_data;
  assign gates        = r_reg.gates;
  assign clutch_drive = r_reg.clutch_drive;
  assign brake_drive  = r_reg.brake_drive;
  assign inhibit_line = r_reg.inhibit;
  assign fault_code   = r_reg.fault_code;
  assign irq          = r_reg.irq;

endmodule : clutch_brake_interlock

// ===== testbench/interlock_checker.sv
// Port assertions for the clutch/brake interlock.
// Assumes ce held high; attached by the bind at the foot.
`timescale 1ns/1ps
`include "interlock_regs.svh"

module interlock_checker
  import interlock_pkg::*;
#(
  parameter logic [7:0] GAP_CYC = 8'h02
) (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire level_t                   speed_ref,
  input wire level_t                   speed_fb,
  input wire logic signed [`SPD_W-1:0] clutch_coil_volt,
  input wire cond_t                    cond,
  input wire logic [`FAULT_N-1:0]      fault_in,
  input wire gates_t                   gates,
  input wire level_t                   clutch_drive,
  input wire level_t                   brake_drive,
  input wire logic                     inhibit_line,
  input wire logic [15:0]              fault_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // --------
  // Gap tracking
  // --------
  // Cycles since an overspeed clutch drop; zero once either gate is back
  logic [7:0] gap_reg;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) gap_reg <= 8'h00;
    else if ($fell(gates.clutch_gate) && $past(speed_fb) > $past(speed_ref)) gap_reg <= 8'h01;
    else if (gates.clutch_gate || gates.brake_gate) gap_reg <= 8'h00;
    else if (gap_reg != 8'h00 && gap_reg != 8'hff) gap_reg <= gap_reg + 8'h01;
  end

  // --------
  // Assertions
  // --------
  a_never_both: assert property (!(gates.clutch_gate && gates.brake_gate))
    else $error("Clutch and brake gated together");
  a_clutch_cause: assert property (gates.clutch_gate |-> $past(speed_ref) > $past(speed_fb))
    else $error("Clutch gated without reference above feedback");
  a_brake_cause: assert property (gates.brake_gate |-> $past(speed_fb) > $past(speed_ref))
    else $error("Brake gated without feedback above reference");
  a_drive_off: assert property ((gates.clutch_gate || clutch_drive == 12'h000) && (gates.brake_gate || brake_drive == 12'h000))
    else $error("Drive present on a gated-off channel");
  a_clutch_block: assert property ($past(rst_n) && $past(!cond.run || !cond.clutch_contactor
    || cond.regulator_inhibit || !cond.phase_ok) |-> !gates.clutch_gate && inhibit_line)
    else $error("Clutch not held off by its permissives");
  a_brake_block: assert property ($past(rst_n) && $past(!cond.brake_contactor || !cond.phase_ok)
    |-> !gates.brake_gate && inhibit_line)
    else $error("Brake not held off by its permissives");
  a_gap_start: assert property ($fell(gates.clutch_gate) && $past(speed_fb) > $past(speed_ref) |-> inhibit_line)
    else $error("Inhibit low at an overspeed clutch drop");
  a_gap_hold: assert property (gap_reg != 8'h00 && gap_reg <= GAP_CYC |-> inhibit_line && gates == 4'h0)
    else $error("Gate or inhibit wrong inside the gap");
  a_gap_length: assert property ($rose(gates.brake_gate) |-> gap_reg == 8'h00 || gap_reg > GAP_CYC)
    else $error("Brake raised before the gap ran out");
  a_main_fault: assert property ($past(rst_n) && $past(fault_in[0]) |-> fault_code == 16'h0101)
    else $error("Most urgent fault not reported first");
  a_no_fault: assert property ($past(rst_n) && !$past(|fault_in) |-> fault_code == 16'h0000)
    else $error("Fault code without an active fault");
  a_freewheel: assert property (gates.freewheel_clutch |-> $past(clutch_coil_volt[`SPD_W-1]))
    else $error("Free-wheel without reversed coil voltage");

  c_clutch: cover property ($rose(gates.clutch_gate));
  c_brake: cover property ($rose(gates.brake_gate) && gap_reg != 8'h00);
  c_fault: cover property (fault_code == 16'h0329);
endmodule : interlock_checker

bind clutch_brake_interlock interlock_checker #(.GAP_CYC(GAP_CYC)) i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .speed_ref(speed_ref), .speed_fb(speed_fb),
  .clutch_coil_volt(clutch_coil_volt), .cond(cond), .fault_in(fault_in), .gates(gates),
  .clutch_drive(clutch_drive), .brake_drive(brake_drive), .inhibit_line(inhibit_line),
  .fault_code(fault_code)
);

// ===== testbench/press_regulator_model.sv
// Behavioural press and regulator feedback for the interlock bench.
// Assumes load is held at start so feedback is never unknown.
`timescale 1ns/1ps

module press_regulator_model
  import interlock_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire gates_t gates,
  input  wire logic   step_en,
  input  wire logic   load,
  input  wire level_t load_val,
  output level_t      speed_fb
);
  // Clutch speeds the press a step a cycle, brake slows it; overshoot is real
  always_ff @(posedge clk_sys) begin
    if (load) speed_fb <= load_val;
    else if (step_en && gates.clutch_gate) speed_fb <= speed_fb + 12'h001;
    else if (step_en && gates.brake_gate) speed_fb <= speed_fb - 12'h001;
  end
endmodule : press_regulator_model

// ===== testbench/clutch_brake_interlock_tb.sv
// Self-checking bench for the clutch/brake interlock.
// Assumes a 40 MHz clock and a gap of two cycles for short runs.
`timescale 1ns/1ps
`include "interlock_regs.svh"

module clutch_brake_interlock_tb
  import interlock_pkg::*;
;
  localparam logic [8:0]          CLU_M = 9'h03f;
  localparam logic [8:0]          BRK_M = 9'h0e8;
  localparam logic [`FAULT_N-1:0] F1    = 45'h1;
  logic                     clk_sys, rst_n, ce, wr_en, rd_en, ld, step, inhibit_line, irq;
  logic [`ADDR_W-1:0]       addr;
  logic [31:0]              wr_data, rd_data, v;
  level_t                   speed_ref, speed_fb, clutch_current, brake_current, line_volt;
  level_t                   ld_val, clutch_drive, brake_drive;
  logic signed [`SPD_W-1:0] clutch_coil_volt, brake_coil_volt;
  cond_t                    cond;
  logic [`FAULT_N-1:0]      fault_in;
  gates_t                   gates;
  logic [15:0]              fault_code;
  int                       fails, n_compared;

  clutch_brake_interlock #(.GAP_CYC(8'h02)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .speed_ref(speed_ref),
    .speed_fb(speed_fb), .clutch_current(clutch_current), .brake_current(brake_current),
    .clutch_coil_volt(clutch_coil_volt), .brake_coil_volt(brake_coil_volt),
    .line_volt(line_volt), .cond(cond), .fault_in(fault_in), .gates(gates),
    .clutch_drive(clutch_drive), .brake_drive(brake_drive), .inhibit_line(inhibit_line),
    .fault_code(fault_code), .irq(irq));
  press_regulator_model i_plant (.clk_sys(clk_sys), .gates(gates), .step_en(step),
    .load(ld), .load_val(ld_val), .speed_fb(speed_fb));

  // --------
  // Tasks
  // --------
  task tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tk
  // Waits n edges then settles to the falling edge for sampling
  task lk(input int n);
    tk(n);
    @(negedge clk_sys);
  endtask : lk
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task gb(input logic [2:0] exp);
    chk("clutch brake inhibit", {gates.clutch_gate, gates.brake_gate, inhibit_line}, exp);
  endtask : gb
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask : rd
  // Feedback is loaded one edge ahead so reference and feedback land together
  task sp(input level_t r, input level_t f);
    @(posedge clk_sys);
    ld <= 1'b1;
    ld_val <= f;
    @(posedge clk_sys);
    ld <= 1'b0;
    speed_ref <= r;
  endtask : sp
  task app(input int i, input logic on);
    case (i)
      0: cond.run <= !on;
      1: cond.clutch_contactor <= !on;
      2: cond.regulator_inhibit <= on;
      3: cond.phase_ok <= !on;
      4: clutch_current <= on ? 12'h866 : 12'h000;
      5: line_volt <= on ? 12'h6cc : 12'h800;
      6: cond.brake_contactor <= !on;
      7: brake_current <= on ? 12'h866 : 12'h000;
      default: line_volt <= on ? 12'h6cd : 12'h800;
    endcase
  endtask : app
  // Each permissive in turn against the running channel, then restored
  task blocks(input logic brk);
    for (int i = 0; i < 9; i++) begin
      tk(1);
      app(i, 1'b1);
      lk(1);
      chk("gate", brk ? gates.brake_gate : gates.clutch_gate, brk ? !BRK_M[i] : !CLU_M[i]);
      chk("inhibit", inhibit_line, i < 8);
      tk(1);
      app(i, 1'b0);
      lk(10);
    end
  endtask : blocks
  function automatic logic [15:0] code_of(input int i);
    int n;
    n = (i == 0) ? 1 : (i < 28) ? i + 1 : i - 15;
    return {(i == 0) ? 8'h01 : (i < 28) ? 8'h02 : 8'h03, 4'(n / 10), 4'(n % 10)};
  endfunction : code_of
  task test_done;
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  // --------
  // Clock, watchdog, tests
  // --------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Tests need about 430 cycles; over forty times that means a hang
  initial begin
    tk(20000);
    fails++;
    test_done();
  end
  initial begin
    {rst_n, wr_en, rd_en, step, addr, wr_data, speed_ref} = '0;
    {clutch_current, brake_current, clutch_coil_volt, brake_coil_volt, fault_in} = '0;
    {ce, ld, ld_val, line_volt, cond} = {2'b11, 12'h000, 12'h800, 5'b11101};
    tk(20);
    rst_n <= 1'b1;
    rd(`OFS_MASK, v);
    chk("mask reset", v, 32'h0);
    wr(`OFS_CTRL, 32'h1);
    rd(`OFS_CTRL, v);
    chk("ctrl", v, 32'h1);
    lk(1);
    chk("read slot", rd_data, 32'h0);
    rd(8'h40, v);
    chk("unmapped", v, 32'h0);
    sp(12'h300, 12'h100);
    lk(1);
    gb(3'b100);
    chk("clutch drive", clutch_drive, 12'h200);
    tk(1);
    clutch_current <= 12'h6f0;
    lk(1);
    chk("limited drive", clutch_drive, 12'h040);
    tk(1);
    clutch_current <= 12'h000;
    blocks(1'b0);
    sp(12'h300, 12'h380);
    for (int j = 0; j < 3; j++) begin
      lk(1);
      gb(3'b001);
    end
    lk(1);
    gb(3'b010);
    chk("brake drive", brake_drive, 12'h080);
    blocks(1'b1);
    sp(12'h300, 12'h300);
    lk(1);
    gb(3'b000);
    chk("brake drive off", brake_drive, 12'h000);
    sp(12'h108, 12'h100);
    tk(1);
    step <= 1'b1;
    @(negedge clk_sys);
    for (int j = 0; j < 40 && speed_fb !== speed_ref; j++) @(negedge clk_sys);
    lk(1);
    chk("clutch at reference", {gates.clutch_gate, clutch_drive}, 13'h0000);
    tk(1);
    step <= 1'b0;
    sp(12'h300, 12'h300);
    tk(1);
    clutch_coil_volt <= 12'hf00;
    brake_coil_volt <= 12'hf00;
    lk(2);
    chk("free-wheel", {gates.freewheel_clutch, gates.freewheel_brake}, 2'b11);
    sp(12'h300, 12'h100);
    lk(1);
    chk("free-wheel gated", gates.freewheel_clutch, 1'b0);
    tk(1);
    {clutch_coil_volt, brake_coil_volt} <= '0;
    for (int i = 0; i < `FAULT_N; i++) begin
      tk(1);
      fault_in <= F1 << i;
      lk(1);
      chk("fault code", fault_code, code_of(i));
    end
    tk(1);
    fault_in <= (F1 << 44) | (F1 << 30) | (F1 << 5);
    lk(1);
    chk("fault ranking", fault_code, 16'h0206);
    tk(1);
    fault_in <= '0;
    wr(`OFS_MASK, 32'h0);
    rd(`OFS_STATUS, v);
    tk(1);
    cond.run <= 1'b0;
    lk(2);
    chk("irq masked", irq, 1'b0);
    wr(`OFS_MASK, 32'h1);
    lk(2);
    chk("irq", irq, 1'b1);
    rd(`OFS_STATUS, v);
    chk("status", v & 32'h1, 32'h1);
    tk(1);
    cond.run <= 1'b1;
    lk(2);
    chk("irq cleared", irq, 1'b0);
    // Clock enable low: inputs and strobes are ignored, outputs hold
    tk(1);
    ce <= 1'b0;
    fault_in <= F1 << 5;
    wr(`OFS_MASK, 32'h0);
    lk(2);
    chk("frozen code", fault_code, 16'h0000);
    tk(1);
    ce <= 1'b1;
    lk(1);
    chk("thawed code", fault_code, 16'h0206);
    rd(`OFS_MASK, v);
    chk("mask kept", v, 32'h1);
    // Reset in mid-run drops enable, so both channels are blocked again
    tk(1);
    rst_n <= 1'b0;
    tk(2);
    rst_n <= 1'b1;
    lk(1);
    gb(3'b001);
    rd(`OFS_CTRL, v);
    chk("ctrl after reset", v, 32'h0);
    test_done();
  end
endmodule : clutch_brake_interlock_tb
